// ---- rtl/lift_out_pkg.sv ----
// Package: register map, fault codes and field constants for the lift output encoder
package lift_out_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_FLOOR    = 8'h04;
  localparam logic [7:0] ADDR_LFAULT   = 8'h08;
  localparam logic [7:0] ADDR_DFAULT   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_CONTACTOR = 0;
  localparam int CTRL_BRAKE     = 1;
  localparam int CTRL_DECEL     = 2;
  localparam int CTRL_SHOW_REQ  = 3;
  localparam int FLOOR_CUR_LSB  = 0;
  localparam int FLOOR_REQ_LSB  = 8;
  localparam int FLOOR_CALL_LSB = 16;
  localparam int FLOOR_W        = 5;
  localparam int FAULT_W        = 4;
  localparam int LFAULT_W       = 11;
  localparam int DFAULT_W       = 15;
  localparam int IRQ_W          = 3;
  localparam int IRQ_LFAULT     = 0;
  localparam int IRQ_DFAULT     = 1;
  localparam int IRQ_GRANT      = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] FLOOR_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ****************************************************************
  // Fault codes: fault source i gives code i+1, code 0 means no fault
  // ****************************************************************
  localparam logic [3:0] FAULT_NONE = 4'h0;
  typedef logic [3:0] fault_code_t;

  // AHB transfer type and size
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;

endpackage

// ---- rtl/fault_if.sv ----
// Interface: fault sources and the encoded fault bus between encoder and top
`timescale 1ns/1ns
`default_nettype none
interface fault_if;
  logic [10:0] lift_act;
  logic [14:0] drive_act;
  logic [3:0]  code;
  logic        is_lift;
  modport enc (input lift_act, input drive_act, output code, output is_lift);
  modport top (output lift_act, output drive_act, input code, input is_lift);
endinterface
`default_nettype wire

// ---- rtl/fault_prio_enc.sv ----
// Priority encoder for lift and drive faults onto a 4-bit fault bus
`timescale 1ns/1ns
`default_nettype none
module fault_prio_enc
  import lift_out_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic clk_en_i,
  // Fault bus
  fault_if.enc      flt
);

  logic [3:0] nxt_code;
  logic       nxt_lift;
  logic [3:0] code_ff;
  logic       lift_ff;

  // Lowest numbered active source wins within each set
  always_comb
  begin
    nxt_code = FAULT_NONE;
    nxt_lift = 1'b0;
    for (int i = DFAULT_W - 1; i >= 0; i--)
      if (flt.drive_act[i])
        nxt_code = 4'(i + 1);
    for (int i = LFAULT_W - 1; i >= 0; i--)
      if (flt.lift_act[i])
      begin
        nxt_code = 4'(i + 1);
        nxt_lift = 1'b1;
      end
  end

  // Registered so the code and its flag change on the same edge
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      code_ff <= FAULT_NONE;
      lift_ff <= 1'b0;
    end
    else if (clk_en_i)
    begin
      code_ff <= nxt_code;
      lift_ff <= nxt_lift;
    end
  end

  assign flt.code    = code_ff;
  assign flt.is_lift = lift_ff;

endmodule
`default_nettype wire

// ---- rtl/floor_sync.sv ----
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ns
`default_nettype none
module floor_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         clk_en_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Elaboration-time guard: a zero-width bank has nothing to carry
  if (W < 1)
  begin : g_bad_width
    $error("floor_sync: W must be at least 1");
  end

  // First stage is read only by the second
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else if (clk_en_i)
    begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule
`default_nettype wire

// ---- rtl/lift_status_fault_encoder.sv ----
// Lift output signalling: floor code, decel approval, relays, fault bus, AHB-Lite regs
// Contract
// - Grant approval only when stop equals calling floor
// - Floor-select flag high when showing stop floor
// - Decelerating flag follows motor deceleration
// - Floor code five bits, bits 3-4 upper
// - Four-bit fault code, all off without fault
// - Lift fault beats drive fault
// - Lift-fault aux output marks lift code set
// - Lift fault codes one to eleven
// - Drive fault codes one to fifteen
// - Contactor relay opens or closes drive output
// - Separate brake relay drives machine brake
// - Floor 1 all off, floor 32 all on
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module lift_status_fault_encoder
  import lift_out_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Lift controller pins
  input  wire logic        decel_approval_request_i,
  output logic             decel_approval_grant_o,
  output logic [4:0]       floor_code_o,
  output logic             floor_select_flag_o,
  output logic             decelerating_flag_o,
  // Relays
  output logic             contactor_relay_o,
  output logic             brake_relay_o,
  // Fault bus
  input  wire logic [10:0] lift_fault_i,
  input  wire logic [14:0] drive_fault_i,
  output logic [3:0]       fault_code_o,
  output logic             aux_output_1_o,
  // Interrupt
  output logic             irq_o
);
  import lift_out_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic [31:0] ctrl_ff;
  logic [31:0] floor_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic        wr_pend_ff;
  logic        rd_pend_ff;
  logic [7:0]  addr_ff;
  logic [31:0] rdata_ff;
  logic        req_s;
  logic        grant_ff;
  logic        grant_q_ff;
  logic        lift_q_ff;
  logic        drv_q_ff;
  logic [4:0]  nxt_floor;
  logic        nxt_grant;
  logic [31:0] nxt_rdata;
  logic        wr_stat;
  logic [IRQ_W-1:0] ev;
  logic        take;

  fault_if flt ();

  // ****************************************************************
  // Synchronisers and fault encoder
  // ****************************************************************
  floor_sync #(.W(1 + LFAULT_W + DFAULT_W)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .clk_en_i  (clk_en_i),
    .d_i       ({decel_approval_request_i, lift_fault_i, drive_fault_i}),
    .q_o       ({req_s, flt.lift_act, flt.drive_act})
  );

  fault_prio_enc u_enc (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .clk_en_i  (clk_en_i),
    .flt       (flt)
  );

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Zero-wait slave: address phase latched, data phase next cycle
  assign take = hsel_i && hready_i && htrans_i[1];

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end
    else if (clk_en_i)
    begin
      wr_pend_ff <= take && hwrite_i;
      rd_pend_ff <= take && !hwrite_i;
      if (take)
        addr_ff <= haddr_i[7:0];
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    nxt_rdata = ZERO_WORD;
    unique case (haddr_i[7:0])
      ADDR_CTRL:     nxt_rdata = ctrl_ff;
      ADDR_FLOOR:    nxt_rdata = floor_ff;
      ADDR_LFAULT:   nxt_rdata = {21'h0, flt.lift_act};
      ADDR_DFAULT:   nxt_rdata = {17'h0, flt.drive_act};
      ADDR_STATUS:   nxt_rdata = {24'h0, grant_ff, req_s, flt.is_lift, 1'b0, flt.code};
      ADDR_IRQ_STAT: nxt_rdata = {29'h0, irq_stat_ff};
      ADDR_IRQ_MASK: nxt_rdata = {29'h0, irq_mask_ff};
      default:       nxt_rdata = ZERO_WORD;
    endcase
  end

  // Read data captured at the address phase, stands in the data phase
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_ff <= ZERO_WORD;
    else if (clk_en_i && take && !hwrite_i)
      rdata_ff <= nxt_rdata;
  end

  assign hrdata_o    = rdata_ff;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // ****************************************************************
  // Control and floor registers
  // ****************************************************************
  // Software steers relays, decel flag and floor values
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_ff  <= CTRL_RST;
      floor_ff <= FLOOR_RST;
    end
    else if (clk_en_i && wr_pend_ff)
    begin
      if (addr_ff == ADDR_CTRL)
        ctrl_ff <= {28'h0, hwdata_i[3:0]};
      if (addr_ff == ADDR_FLOOR)
        floor_ff <= {11'h0, hwdata_i[20:16], 3'h0, hwdata_i[12:8], 3'h0, hwdata_i[4:0]};
    end
  end

  // ****************************************************************
  // Terminal outputs
  // ****************************************************************
  // Stop floor or current floor, 0 means floor 1, 31 floor 32
  always_comb
  begin
    if (ctrl_ff[CTRL_SHOW_REQ])
      nxt_floor = floor_ff[FLOOR_REQ_LSB +: FLOOR_W];
    else
      nxt_floor = floor_ff[FLOOR_CUR_LSB +: FLOOR_W];
  end

  // Grant only while request held and floors match
  assign nxt_grant = req_s &&
    (floor_ff[FLOOR_REQ_LSB +: FLOOR_W] == floor_ff[FLOOR_CALL_LSB +: FLOOR_W]);

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      floor_code_o        <= 5'h00;
      floor_select_flag_o <= 1'b0;
      decelerating_flag_o <= 1'b0;
      contactor_relay_o   <= 1'b0;
      brake_relay_o       <= 1'b0;
      grant_ff            <= 1'b0;
    end
    else if (clk_en_i)
    begin
      floor_code_o        <= nxt_floor;
      floor_select_flag_o <= ctrl_ff[CTRL_SHOW_REQ];
      decelerating_flag_o <= ctrl_ff[CTRL_DECEL];
      contactor_relay_o   <= ctrl_ff[CTRL_CONTACTOR];
      brake_relay_o       <= ctrl_ff[CTRL_BRAKE];
      grant_ff            <= nxt_grant;
    end
  end

  assign decel_approval_grant_o = grant_ff;
  assign fault_code_o           = flt.code;
  assign aux_output_1_o         = flt.is_lift;

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  // Rising-edge events: new lift fault, new drive fault, grant given
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      grant_q_ff <= 1'b0;
      lift_q_ff  <= 1'b0;
      drv_q_ff   <= 1'b0;
    end
    else if (clk_en_i)
    begin
      grant_q_ff <= grant_ff;
      lift_q_ff  <= |flt.lift_act;
      drv_q_ff   <= |flt.drive_act;
    end
  end

  assign ev[IRQ_LFAULT] = (|flt.lift_act) && !lift_q_ff;
  assign ev[IRQ_DFAULT] = (|flt.drive_act) && !drv_q_ff;
  assign ev[IRQ_GRANT]  = grant_ff && !grant_q_ff;
  assign wr_stat        = wr_pend_ff && (addr_ff == ADDR_IRQ_STAT);

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
    end
    else if (clk_en_i)
    begin
      irq_stat_ff <= (irq_stat_ff & ~(wr_stat ? hwdata_i[IRQ_W-1:0] : '0)) | ev;
      if (wr_pend_ff && addr_ff == ADDR_IRQ_MASK)
        irq_mask_ff <= hwdata_i[IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat_ff & irq_mask_ff);

endmodule
`default_nettype wire

// ---- tb/lsfe_checker.sv ----
// Checker: port-level assertions for the lift output encoder
`timescale 1ns/1ns
`default_nettype none
module lsfe_checker
  import lift_out_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Bus
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  // Pins
  input  wire logic        decel_approval_request_i,
  input  wire logic        decel_approval_grant_o,
  input  wire logic        floor_select_flag_o,
  input  wire logic        decelerating_flag_o,
  input  wire logic        contactor_relay_o,
  input  wire logic        brake_relay_o,
  input  wire logic [10:0] lift_fault_i,
  input  wire logic [14:0] drive_fault_i,
  input  wire logic [3:0]  fault_code_o,
  input  wire logic        aux_output_1_o
);
  // ****************************************************************
  // Helpers and assertions
  // ****************************************************************
  logic       ctrl_dp_ff;
  logic [3:0] exp_code;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Lowest source wins; any lift source beats every drive source
  function automatic logic [3:0] enc(input logic [10:0] l, input logic [14:0] d);
    enc = 4'h0;
    for (int i = 14; i >= 0; i--)
      if (d[i]) enc = 4'(i + 1);
    for (int i = 10; i >= 0; i--)
      if (l[i]) enc = 4'(i + 1);
  endfunction
  assign exp_code = enc(lift_fault_i, drive_fault_i);

  // Data phase of a control write, so pin checks know when to look
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ctrl_dp_ff <= 1'b0;
    else if (hready_i)
      ctrl_dp_ff <= hsel_i && htrans_i[1] && hwrite_i && haddr_i[7:0] == ADDR_CTRL;
  end

  grant_source_a:
    assert property (decel_approval_grant_o |-> $past(decel_approval_request_i, 3))
    else $error("grant without request");
  fault_exact_a:
    assert property (1'b1 |-> fault_code_o == $past(exp_code, 3))
    else $error("fault code wrong");
  fault_clear_a:
    assert property ($past(lift_fault_i, 3) == 11'h0 && $past(drive_fault_i, 3) == 15'h0
      |-> fault_code_o == 4'h0 && !aux_output_1_o)
    else $error("fault bus not idle");
  lift_flag_a:
    assert property ($past(lift_fault_i, 3) != 11'h0 |-> aux_output_1_o)
    else $error("lift flag missing");
  drive_flag_a:
    assert property ($past(lift_fault_i, 3) == 11'h0 && $past(drive_fault_i, 3) != 15'h0
      |-> !aux_output_1_o && fault_code_o != 4'h0)
    else $error("drive code flagged as lift");
  relay_follow_a:
    assert property (ctrl_dp_ff && hready_i |-> ##2
      contactor_relay_o == $past(hwdata_i[CTRL_CONTACTOR], 2) &&
      brake_relay_o == $past(hwdata_i[CTRL_BRAKE], 2))
    else $error("relay outputs wrong");
  decel_flag_a:
    assert property (ctrl_dp_ff && hready_i |-> ##2
      decelerating_flag_o == $past(hwdata_i[CTRL_DECEL], 2))
    else $error("decel flag wrong");
  select_flag_a:
    assert property (ctrl_dp_ff && hready_i |-> ##2
      floor_select_flag_o == $past(hwdata_i[CTRL_SHOW_REQ], 2))
    else $error("floor select flag wrong");
endmodule
`default_nettype wire

// ---- tb/lift_ctrl_model.sv ----
// Lift controller model: raises and holds the deceleration approval request
`timescale 1ns/1ns
`default_nettype none
module lift_ctrl_model
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Bench control
  input  wire logic ask_i,
  input  wire logic drop_i,
  // Device pins
  input  wire logic grant_i,
  output logic      req_o
);
  // Held until the grant is seen; the bench may give up on a wrong floor
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      req_o <= 1'b0;
    else
      req_o <= ask_i || (req_o && !grant_i && !drop_i);
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Testbench: bus-driven scenarios for the lift output encoder
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import lift_out_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0;
  logic        ask       = 1'b0;
  logic        drop      = 1'b0;
  logic [10:0] lflt      = 11'h0;
  logic [14:0] dflt      = 15'h0;
  logic [31:0] rdata;
  logic [4:0]  floor;
  logic [3:0]  code;
  logic        ready, resp, req, grant, fsel, decel, cont, brake, aux, irq;
  int          miscompares = 0;
  int          cmp_count   = 0;
  int          cycles      = 0;

  lift_status_fault_encoder lift_status_fault_encoder_inst (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(HSIZE_WORD), .hwdata_i(hwdata), .hready_i(ready), .hrdata_o(rdata),
    .hreadyout_o(ready), .hresp_o(resp), .decel_approval_request_i(req),
    .decel_approval_grant_o(grant), .floor_code_o(floor), .floor_select_flag_o(fsel),
    .decelerating_flag_o(decel), .contactor_relay_o(cont), .brake_relay_o(brake),
    .lift_fault_i(lflt), .drive_fault_i(dflt), .fault_code_o(code),
    .aux_output_1_o(aux), .irq_o(irq));
  lift_ctrl_model lift_ctrl_model_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .ask_i(ask), .drop_i(drop), .grant_i(grant), .req_o(req));

  // ****************************************************************
  // Clock, timeout and tasks
  // ****************************************************************
  always #2 ref_clk_i = ~ref_clk_i;

  // A hung wait must still reach the report
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single AHB transfer; read data stays in rdata afterwards
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk_i); while (ready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk_i); while (ready !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rdata, exp);
  endtask

  // Pins settle within three edges of their cause
  task automatic settle();
    repeat (4) @(posedge ref_clk_i);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    chk({resp, ready}, 32'h1);
    chk({code, aux, floor, cont, brake, decel, fsel, grant}, 32'h0);
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_FLOOR, FLOOR_RST);
    rd(8'h20, ZERO_WORD);
    for (int i = 0; i < 16; i++)
    begin
      xfer(ADDR_CTRL, 1'b1, 32'(i));
      settle();
      chk({fsel, decel, brake, cont}, 32'(i));
    end
    xfer(ADDR_FLOOR, 1'b1, 32'h001f_1f18);
    xfer(ADDR_CTRL, 1'b1, 32'h0);
    settle();
    chk(floor, 32'h18);
    xfer(ADDR_CTRL, 1'b1, 32'h8);
    settle();
    chk(floor, 32'h1f);
    xfer(ADDR_FLOOR, 1'b1, 32'h001f_0000);
    settle();
    chk(floor, 32'h0);
    // Stop floor differs from calling floor: no grant however long we ask
    ask <= 1'b1;
    @(posedge ref_clk_i);
    ask <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    chk({req, grant}, 32'h2);
    drop <= 1'b1;
    @(posedge ref_clk_i);
    drop <= 1'b0;
    xfer(ADDR_FLOOR, 1'b1, 32'h001f_1f00);
    ask <= 1'b1;
    @(posedge ref_clk_i);
    ask <= 1'b0;
    while (grant !== 1'b1) @(posedge ref_clk_i);
    settle();
    settle();
    chk({req, grant}, 32'h0);
    for (int i = 0; i < 26; i++)
    begin
      {dflt, lflt} <= 26'h1 << i;
      settle();
      chk({aux, code}, i < 11 ? 32'h10 + i + 1 : 32'(i - 10));
    end
    {dflt, lflt} <= {15'h1, 11'h008};
    settle();
    chk({aux, code}, 32'h14);
    repeat (20) @(posedge ref_clk_i);
    chk({aux, code}, 32'h14);
    lflt <= 11'h0;
    settle();
    chk({aux, code}, 32'h01);
    dflt <= 15'h0;
    settle();
    chk({aux, code}, 32'h0);
    // Interrupt: raise through the mask, then clear by writing ones
    chk(irq, 32'h0);
    rd(ADDR_IRQ_STAT, 32'h7);
    xfer(ADDR_IRQ_MASK, 1'b1, 32'h1);
    settle();
    chk(irq, 32'h1);
    xfer(ADDR_IRQ_STAT, 1'b1, 32'h1);
    settle();
    chk(irq, 32'h0);
    rd(ADDR_IRQ_STAT, 32'h6);
    xfer(ADDR_IRQ_MASK, 1'b1, 32'h6);
    settle();
    chk(irq, 32'h1);
    xfer(ADDR_IRQ_STAT, 1'b1, 32'h6);
    settle();
    chk(irq, 32'h0);
    rd(ADDR_IRQ_MASK, 32'h6);
    xfer(ADDR_LFAULT, 1'b1, 32'h7ff);
    rd(ADDR_LFAULT, ZERO_WORD);
    summarize();
  end
endmodule

bind lift_status_fault_encoder lsfe_checker lsfe_checker_inst (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hwdata_i(hwdata_i),
  .decel_approval_request_i(decel_approval_request_i),
  .decel_approval_grant_o(decel_approval_grant_o),
  .floor_select_flag_o(floor_select_flag_o), .decelerating_flag_o(decelerating_flag_o),
  .contactor_relay_o(contactor_relay_o), .brake_relay_o(brake_relay_o),
  .lift_fault_i(lift_fault_i), .drive_fault_i(drive_fault_i),
  .fault_code_o(fault_code_o), .aux_output_1_o(aux_output_1_o));
`default_nettype wire
